/* rtl/fcc_pkg.sv */
// Shared constants, types and carriers for the float compare/convert datapath
package fcc_pkg;

   // Instruction word fields (8-bit opcode, two 4-bit register fields)
   localparam int OP_MSB = 15;
   localparam int OP_LSB = 8;
   localparam int RA_MSB = 7;
   localparam int RA_LSB = 4;
   localparam int RB_MSB = 3;
   localparam int RB_LSB = 0;

   // Full-byte opcodes
   localparam logic [7:0] OP_FC_MEM = 8'hf8;
   localparam logic [7:0] OP_FC_REG = 8'hf9;
   localparam logic [7:0] OP_EFC_MEM = 8'hfa;
   localparam logic [7:0] OP_EFC_REG = 8'hfb;
   localparam logic [7:0] OP_FIX16 = 8'he8;
   localparam logic [7:0] OP_FLT16 = 8'he9;
   localparam logic [7:0] OP_FIX32 = 8'hea;
   localparam logic [7:0] OP_FLT32 = 8'heb;

   // Base-relative compare layouts: 4-bit major, 2-bit minor, 2-bit base field
   localparam int BF_MAJ_MSB = 15;
   localparam int BF_MAJ_LSB = 12;
   localparam int BF_MIN_MSB = 11;
   localparam int BF_MIN_LSB = 10;
   localparam int BF_BASE_MSB = 9;
   localparam int BF_BASE_LSB = 8;
   localparam logic [3:0] OP_FCB_MAJ = 4'h3;
   localparam logic [1:0] OP_FCB_MIN = 2'h3;
   localparam logic [3:0] OP_SINGLE_FLOAT_COMPARE_BASED_INDEXED_MAJ = 4'h4;
   localparam logic [1:0] OP_SINGLE_FLOAT_COMPARE_BASED_INDEXED_MIN = 2'h0;
   localparam logic [3:0] OP_SINGLE_FLOAT_COMPARE_BASED_INDEXED_EXT = 4'hd;
   localparam logic [3:0] BASE_OFS = 4'hc;
   localparam logic [3:0] REG_ZERO = 4'h0;

   // Three-word float layout: mantissa high, exponent, mantissa low
   localparam int MH_MSB = 47;
   localparam int MH_LSB = 24;
   localparam int EX_MSB = 23;
   localparam int EX_LSB = 16;
   localparam int ML_MSB = 15;
   localparam int ML_LSB = 0;

   // Condition status codes
   localparam logic [3:0] CS_EQ = 4'h2;
   localparam logic [3:0] CS_LT = 4'h1;
   localparam logic [3:0] CS_GT = 4'h4;
   localparam logic [3:0] CS_RST = 4'h0;

   // Exponent limits and initial exponents
   localparam logic [7:0] EXP_INT16 = 8'h0f;
   localparam logic [7:0] EXP_INT32 = 8'h1f;

   // Execution times in clocks
   localparam logic [6:0] CYC_FC_MEM = 7'h3a;
   localparam logic [6:0] CYC_FC_BASE = 7'h3a;
   localparam logic [6:0] CYC_EFC_MEM = 7'h41;
   localparam logic [6:0] CYC_CMP_REG = 7'h34;
   localparam logic [6:0] CYC_FIX16 = 7'h0a;
   localparam logic [6:0] CYC_FLT16 = 7'h10;
   localparam logic [6:0] CYC_FIX32 = 7'h15;
   localparam logic [6:0] CYC_FLT32 = 7'h19;
   localparam logic [6:0] CYC_BAD = 7'h01;

   // Operand bus cycles per form
   localparam logic [1:0] OPB_FC_MEM = 2'h2;
   localparam logic [1:0] OPB_FC_BASE = 2'h2;
   localparam logic [1:0] OPB_EFC_MEM = 2'h3;
   localparam logic [1:0] OPB_NONE = 2'h0;

   // Register words written back
   localparam logic [1:0] WORDS_ONE = 2'h1;
   localparam logic [1:0] WORDS_TWO = 2'h2;
   localparam logic [1:0] WORDS_THREE = 2'h3;

   // Operation kinds
   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_FC = 3'b001,
      K_EFC = 3'b010,
      K_FIX16 = 3'b011,
      K_FLT16 = 3'b100,
      K_FIX32 = 3'b101,
      K_FLT32 = 3'b110
   } fcc_kind_t;

   // Sequencing states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b10
   } fcc_state_t;

   // Request: instruction, first-register group, derived operand
   typedef struct packed {
      logic [15:0] instr;
      logic [47:0] first_val;
      logic [47:0] dop;
   } fcc_req_t;

   // Register write-back
   typedef struct packed {
      logic en;
      logic [3:0] idx;
      logic [1:0] words;
      logic [47:0] data;
   } fcc_wr_t;

endpackage

/* rtl/fcc_normalize.sv */
// Left-normalizer for integer-to-float conversion
`timescale 1ns/100ps
module fcc_normalize #(
   parameter int W = 32,
   parameter int EW = 8
) (
   // Integer as a fraction and its starting exponent
   input wire logic [W-1:0] value_in,
   input wire logic [EW-1:0] exp_in,
   // Normalized mantissa and exponent
   output logic [W-1:0] mant_out,
   output logic [EW-1:0] exp_out
);

   // Too narrow for a sign and a next bit
   if (W < 2 || EW < 2) begin : g_bad_width
      $error("fcc_normalize: W and EW must be at least 2");
   end

   // Shift until sign and next bit differ; zero gives zero
   always_comb begin
      logic [W-1:0] m;
      logic [EW-1:0] e;
      logic stop;
      m = value_in;
      e = exp_in;
      stop = 1'b0;
      for (int i = 0; i < W - 1; i++) begin
         if (!stop && (m[W-1] == m[W-2])) begin
            m = m << 1;
            e = e - EW'(1);
         end else begin
            stop = 1'b1;
         end
      end
      if (value_in == '0) begin
         mant_out = '0;
         exp_out = '0;
      end else begin
         mant_out = m;
         exp_out = e;
      end
   end

endmodule // fcc_normalize

/* rtl/fcc_top.sv */
// Float compare and integer/float conversion datapath
`timescale 1ns/100ps
// Operation
// - Single compare sets 0010, 0001 or 0100
// - Extended compare uses three words, first most significant
// - Compares: no overflow, no register write, CS only
// - Single compare opcodes F8 memory, F9 register
// - Extended compare opcodes FA memory, FB register
// - Base forms: base 12..15, field plus 12, R0
// - Compare times 58, 65 and 52 clocks
// - To-16-bit with exponent over 0F: overflow, no write
// - Conversions truncate toward zero, CS from result
// - To-16-bit is E8, two words in, 10 clocks
// - 16-bit to float: zero stays zero, else exponent 0F
// - Normalize: shift left, decrement until top bits differ
// - Same source and destination works; CS from float
// - 16-bit to float is E9, two words out, 16 clocks
// - To-32-bit with exponent over 1F: overflow, no write
// - To-32-bit is EA, three words in, 21 clocks
// - 32-bit to extended: exponent 1F, normalize, three words
// - 32-bit to extended is EB, 25 clocks
module fcc_top (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // Request from the sequencer
   input wire logic START,
   input wire fcc_pkg::fcc_req_t REQ,
   // Progress
   output logic BUSY,
   output logic DONE,
   output logic BAD_OP,
   // Decoded operand information
   output logic [3:0] FIRST_REGISTER,
   output logic [3:0] BASE_REGISTER,
   output logic [1:0] OPND_BUS,
   // Results
   output logic [3:0] CS,
   output logic CS_WE,
   output fcc_pkg::fcc_wr_t WR,
   output logic FIX_OVF_PI
);

   // Instruction fields
   logic [7:0] opc;
   logic [3:0] ra;
   logic [3:0] rb;

   // Decode results
   fcc_pkg::fcc_kind_t kind;
   logic [6:0] cyc;
   logic [3:0] first_reg;
   logic [3:0] base_reg;
   logic [1:0] opbus;
   logic ext;

   // Operand mantissas and exponents
   logic signed [39:0] ma;
   logic signed [39:0] mb;
   logic [7:0] ea;
   logic [7:0] operand_exponent;

   // Compare path
   logic signed [8:0] ediff;
   logic [5:0] sha;
   logic [5:0] shb;
   logic signed [87:0] wa;
   logic signed [87:0] wb;
   logic [3:0] cmp_cs;

   // Float-to-integer path
   logic signed [8:0] fx_sh;
   logic signed [40:0] fx_m;
   logic [40:0] fx_bias;
   logic signed [40:0] fx_q;
   logic [31:0] fx_int;
   logic fx_ovf16;
   logic fx_ovf32;

   // Integer-to-float path
   logic [31:0] nv_in;
   logic [7:0] ne_in;
   logic [31:0] nm;
   logic [7:0] ne;

   // Pending results captured at the take
   logic [3:0] pcs_q, pcs_d;
   logic pcs_we_q, pcs_we_d;
   logic pwr_en_q, pwr_en_d;
   logic povf_q, povf_d;
   logic pbad_q, pbad_d;
   logic [3:0] pidx_q, pidx_d;
   logic [1:0] pwords_q, pwords_d;
   logic [47:0] pdata_q, pdata_d;

   // Control state
   fcc_pkg::fcc_state_t st_q, st_d;
   logic [6:0] cnt_q, cnt_d;
   logic take;

   // Output flops
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic bad_q, bad_d;
   logic [3:0] first_q, first_d;
   logic [3:0] base_q, base_d;
   logic [1:0] opbus_q, opbus_d;
   logic [3:0] cs_q, cs_d;
   logic cs_we_q, cs_we_d;
   logic wr_en_q, wr_en_d;
   logic [3:0] wr_idx_q, wr_idx_d;
   logic [1:0] wr_words_q, wr_words_d;
   logic [47:0] wr_data_q, wr_data_d;
   logic ovf_q, ovf_d;

   assign opc = REQ.instr[fcc_pkg::OP_MSB:fcc_pkg::OP_LSB];
   assign ra = REQ.instr[fcc_pkg::RA_MSB:fcc_pkg::RA_LSB];
   assign rb = REQ.instr[fcc_pkg::RB_MSB:fcc_pkg::RB_LSB];

   // Opcode decode, timing and operand bus count
   always_comb begin
      kind = fcc_pkg::K_NONE;
      cyc = fcc_pkg::CYC_BAD;
      first_reg = ra;
      base_reg = REG_ZERO_F();
      opbus = fcc_pkg::OPB_NONE;
      ext = 1'b0;
      case (opc)
         fcc_pkg::OP_FC_MEM: begin
            kind = fcc_pkg::K_FC;
            cyc = fcc_pkg::CYC_FC_MEM;
            opbus = fcc_pkg::OPB_FC_MEM;
         end
         fcc_pkg::OP_FC_REG: begin
            kind = fcc_pkg::K_FC;
            cyc = fcc_pkg::CYC_CMP_REG;
         end
         fcc_pkg::OP_EFC_MEM: begin
            kind = fcc_pkg::K_EFC;
            ext = 1'b1;
            cyc = fcc_pkg::CYC_EFC_MEM;
            opbus = fcc_pkg::OPB_EFC_MEM;
         end
         fcc_pkg::OP_EFC_REG: begin
            kind = fcc_pkg::K_EFC;
            ext = 1'b1;
            cyc = fcc_pkg::CYC_CMP_REG;
         end
         fcc_pkg::OP_FIX16: begin
            kind = fcc_pkg::K_FIX16;
            cyc = fcc_pkg::CYC_FIX16;
         end
         fcc_pkg::OP_FLT16: begin
            kind = fcc_pkg::K_FLT16;
            cyc = fcc_pkg::CYC_FLT16;
         end
         fcc_pkg::OP_FIX32: begin
            kind = fcc_pkg::K_FIX32;
            ext = 1'b1;
            cyc = fcc_pkg::CYC_FIX32;
         end
         fcc_pkg::OP_FLT32: begin
            kind = fcc_pkg::K_FLT32;
            cyc = fcc_pkg::CYC_FLT32;
         end
         default: begin
            // Base-relative forms share the opcode space by major nibble
            if ((REQ.instr[fcc_pkg::BF_MAJ_MSB:fcc_pkg::BF_MAJ_LSB] == fcc_pkg::OP_FCB_MAJ &&
                 REQ.instr[fcc_pkg::BF_MIN_MSB:fcc_pkg::BF_MIN_LSB] == fcc_pkg::OP_FCB_MIN) ||
                (REQ.instr[fcc_pkg::BF_MAJ_MSB:fcc_pkg::BF_MAJ_LSB] == fcc_pkg::OP_SINGLE_FLOAT_COMPARE_BASED_INDEXED_MAJ &&
                 REQ.instr[fcc_pkg::BF_MIN_MSB:fcc_pkg::BF_MIN_LSB] == fcc_pkg::OP_SINGLE_FLOAT_COMPARE_BASED_INDEXED_MIN &&
                 ra == fcc_pkg::OP_SINGLE_FLOAT_COMPARE_BASED_INDEXED_EXT)) begin
               kind = fcc_pkg::K_FC;
               first_reg = fcc_pkg::REG_ZERO;
               base_reg = fcc_pkg::BASE_OFS +
                          {2'h0, REQ.instr[fcc_pkg::BF_BASE_MSB:fcc_pkg::BF_BASE_LSB]};
               cyc = fcc_pkg::CYC_FC_BASE;
               opbus = fcc_pkg::OPB_FC_BASE;
            end
         end
      endcase
   end

   // Base field zero when the form has no base
   function automatic logic [3:0] REG_ZERO_F();
      return fcc_pkg::REG_ZERO;
   endfunction

   // Operand unpack; single floats carry no low mantissa word
   always_comb begin
      ea = REQ.first_val[fcc_pkg::EX_MSB:fcc_pkg::EX_LSB];
      operand_exponent = REQ.dop[fcc_pkg::EX_MSB:fcc_pkg::EX_LSB];
      if (ext) begin
         ma = {REQ.first_val[fcc_pkg::MH_MSB:fcc_pkg::MH_LSB], REQ.first_val[fcc_pkg::ML_MSB:fcc_pkg::ML_LSB]};
         mb = {REQ.dop[fcc_pkg::MH_MSB:fcc_pkg::MH_LSB], REQ.dop[fcc_pkg::ML_MSB:fcc_pkg::ML_LSB]};
      end else begin
         ma = {REQ.first_val[fcc_pkg::MH_MSB:fcc_pkg::MH_LSB], 16'h0000};
         mb = {REQ.dop[fcc_pkg::MH_MSB:fcc_pkg::MH_LSB], 16'h0000};
      end
   end

   // Align by exponent then compare signed; wide field keeps it exact
   always_comb begin
      ediff = $signed({ea[7], ea}) - $signed({operand_exponent[7], operand_exponent});
      sha = 6'h00;
      shb = 6'h00;
      if (ediff >= 9'sh000) begin
         shb = (ediff > 9'sh030) ? 6'h30 : ediff[5:0];
      end else begin
         sha = (-ediff > 9'sh030) ? 6'h30 : 6'(-ediff);
      end
      wa = $signed({ma, 48'h0}) >>> sha;
      wb = $signed({mb, 48'h0}) >>> shb;
      if (wa == wb) begin
         cmp_cs = fcc_pkg::CS_EQ;
      end else if (wa < wb) begin
         cmp_cs = fcc_pkg::CS_LT;
      end else begin
         cmp_cs = fcc_pkg::CS_GT;
      end
   end

   // Integer part, rounding negative values up so the cut is toward zero
   always_comb begin
      fx_sh = 9'sh027 - $signed({operand_exponent[7], operand_exponent});
      fx_m = $signed({mb[39], mb});
      fx_bias = 41'h0;
      fx_q = 41'sh0;
      if (fx_sh < 9'sh028) begin
         if (mb[39]) begin
            fx_bias = (41'h1 << fx_sh[5:0]) - 41'h1;
         end
         fx_q = (fx_m + $signed(fx_bias)) >>> fx_sh[5:0];
      end
      fx_int = fx_q[31:0];
      fx_ovf16 = $signed(operand_exponent) > $signed(fcc_pkg::EXP_INT16);
      fx_ovf32 = $signed(operand_exponent) > $signed(fcc_pkg::EXP_INT32);
   end

   // Integer placed as a fraction with its matching start exponent
   always_comb begin
      if (kind == fcc_pkg::K_FLT32) begin
         nv_in = REQ.dop[47:16];
         ne_in = fcc_pkg::EXP_INT32;
      end else begin
         nv_in = {REQ.dop[47:32], 16'h0000};
         ne_in = fcc_pkg::EXP_INT16;
      end
   end

   // Shared normalizer for both integer widths
   fcc_normalize #(
      .W(32),
      .EW(8)
   ) u_norm (
      .value_in(nv_in),
      .exp_in(ne_in),
      .mant_out(nm),
      .exp_out(ne)
   );

   // Sign and zero of a signed value to a status code
   function automatic logic [3:0] sign_cs(input logic neg, input logic zero);
      if (zero) begin
         return fcc_pkg::CS_EQ;
      end else if (neg) begin
         return fcc_pkg::CS_LT;
      end
      return fcc_pkg::CS_GT;
   endfunction

   // Pending result, built while the sequencer holds the operands
   always_comb begin
      pcs_d = pcs_q;
      pcs_we_d = pcs_we_q;
      pwr_en_d = pwr_en_q;
      povf_d = povf_q;
      pbad_d = pbad_q;
      pidx_d = pidx_q;
      pwords_d = pwords_q;
      pdata_d = pdata_q;
      if (take) begin
         pcs_d = pcs_q;
         pcs_we_d = 1'b0;
         pwr_en_d = 1'b0;
         povf_d = 1'b0;
         pbad_d = 1'b0;
         pidx_d = first_reg;
         pwords_d = fcc_pkg::WORDS_ONE;
         pdata_d = 48'h0;
         case (kind)
            fcc_pkg::K_FC, fcc_pkg::K_EFC: begin
               pcs_d = cmp_cs;
               pcs_we_d = 1'b1;
            end
            fcc_pkg::K_FIX16: begin
               povf_d = fx_ovf16;
               pwr_en_d = !fx_ovf16;
               pcs_we_d = !fx_ovf16;
               pcs_d = sign_cs(fx_int[15], fx_int[15:0] == 16'h0000);
               pdata_d = {fx_int[15:0], 32'h0};
            end
            fcc_pkg::K_FIX32: begin
               povf_d = fx_ovf32;
               pwr_en_d = !fx_ovf32;
               pcs_we_d = !fx_ovf32;
               pcs_d = sign_cs(fx_int[31], fx_int == 32'h0);
               pwords_d = fcc_pkg::WORDS_TWO;
               pdata_d = {fx_int, 16'h0};
            end
            fcc_pkg::K_FLT16: begin
               pwr_en_d = 1'b1;
               pcs_we_d = 1'b1;
               pwords_d = fcc_pkg::WORDS_TWO;
               pdata_d = {nm[31:8], ne, 16'h0000};
               pcs_d = sign_cs(nm[31], nm[31:8] == 24'h0);
            end
            fcc_pkg::K_FLT32: begin
               pwr_en_d = 1'b1;
               pcs_we_d = 1'b1;
               pwords_d = fcc_pkg::WORDS_THREE;
               pdata_d = {nm[31:8], ne, nm[7:0], 8'h00};
               pcs_d = sign_cs(nm[31], nm == 32'h0);
            end
            default: begin
               pbad_d = 1'b1;
            end
         endcase
      end
   end

   // Pending result registers
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pcs_q <= fcc_pkg::CS_RST;
         pcs_we_q <= 1'b0;
         pwr_en_q <= 1'b0;
         povf_q <= 1'b0;
         pbad_q <= 1'b0;
         pidx_q <= 4'h0;
         pwords_q <= 2'h0;
         pdata_q <= 48'h0;
      end else begin
         pcs_q <= pcs_d;
         pcs_we_q <= pcs_we_d;
         pwr_en_q <= pwr_en_d;
         povf_q <= povf_d;
         pbad_q <= pbad_d;
         pidx_q <= pidx_d;
         pwords_q <= pwords_d;
         pdata_q <= pdata_d;
      end
   end

   // A new request is taken whenever no instruction is running
   assign take = START && (st_q != fcc_pkg::ST_RUN);

   // Sequencing: count the instruction time, then one done cycle
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      busy_d = 1'b0;
      done_d = 1'b0;
      bad_d = 1'b0;
      first_d = first_q;
      base_d = base_q;
      opbus_d = opbus_q;
      cs_d = cs_q;
      cs_we_d = 1'b0;
      wr_en_d = 1'b0;
      wr_idx_d = wr_idx_q;
      wr_words_d = wr_words_q;
      wr_data_d = wr_data_q;
      ovf_d = 1'b0;
      case (st_q)
         fcc_pkg::ST_RUN: begin
            busy_d = 1'b1;
            if (cnt_q == 7'h00) begin
               // Retire: release the captured result for one cycle
               st_d = fcc_pkg::ST_DONE;
               busy_d = 1'b0;
               done_d = 1'b1;
               bad_d = pbad_q;
               cs_we_d = pcs_we_q;
               cs_d = pcs_we_q ? pcs_q : cs_q;
               wr_en_d = pwr_en_q;
               wr_idx_d = pidx_q;
               wr_words_d = pwords_q;
               wr_data_d = pdata_q;
               ovf_d = povf_q;
            end else begin
               cnt_d = cnt_q - 7'h01;
            end
         end
         fcc_pkg::ST_IDLE, fcc_pkg::ST_DONE: begin
            st_d = fcc_pkg::ST_IDLE;
            if (take) begin
               // Undecodable words retire on the next edge
               if (cyc == fcc_pkg::CYC_BAD) begin
                  st_d = fcc_pkg::ST_RUN;
                  cnt_d = 7'h00;
               end else begin
                  st_d = fcc_pkg::ST_RUN;
                  cnt_d = cyc - 7'h02;
               end
               busy_d = 1'b1;
               first_d = first_reg;
               base_d = base_reg;
               opbus_d = opbus;
            end
         end
         default: begin
            st_d = fcc_pkg::ST_IDLE;
         end
      endcase
   end

   // Control and output registers
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= fcc_pkg::ST_IDLE;
         cnt_q <= 7'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         bad_q <= 1'b0;
         first_q <= 4'h0;
         base_q <= 4'h0;
         opbus_q <= 2'h0;
         cs_q <= fcc_pkg::CS_RST;
         cs_we_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_idx_q <= 4'h0;
         wr_words_q <= 2'h0;
         wr_data_q <= 48'h0;
         ovf_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
         bad_q <= bad_d;
         first_q <= first_d;
         base_q <= base_d;
         opbus_q <= opbus_d;
         cs_q <= cs_d;
         cs_we_q <= cs_we_d;
         wr_en_q <= wr_en_d;
         wr_idx_q <= wr_idx_d;
         wr_words_q <= wr_words_d;
         wr_data_q <= wr_data_d;
         ovf_q <= ovf_d;
      end
   end

   // Ports straight from flops
   assign BUSY = busy_q;
   assign DONE = done_q;
   assign BAD_OP = bad_q;
   assign FIRST_REGISTER = first_q;
   assign BASE_REGISTER = base_q;
   assign OPND_BUS = opbus_q;
   assign CS = cs_q;
   assign CS_WE = cs_we_q;
   assign WR = '{en: wr_en_q, idx: wr_idx_q, words: wr_words_q, data: wr_data_q};
   assign FIX_OVF_PI = ovf_q;

endmodule // fcc_top

/* test/fcc_checker.sv */
// Port-level assertions for the float compare/convert datapath
`timescale 1ns/100ps
module fcc_checker (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // Request and answer
   input wire logic START,
   input wire fcc_pkg::fcc_req_t REQ,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic [3:0] CS,
   input wire logic CS_WE,
   input wire fcc_pkg::fcc_wr_t WR,
   input wire logic FIX_OVF_PI
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   // Opcode of a request taken at this edge
   logic [7:0] op;
   logic take;
   assign op = REQ.instr[15:8];
   assign take = START && !BUSY;

   done_pulse_a: assert property (DONE |=> !DONE) else $error("done wider than one cycle");
   cs_quiet_a: assert property (!CS_WE |=> $stable(CS) || CS_WE) else $error("status moved without strobe");
   cs_code_a: assert property (CS_WE |-> CS inside {4'h1, 4'h2, 4'h4}) else $error("bad status code");
   ovf_nowrite_a: assert property (FIX_OVF_PI |-> DONE && !WR.en && !CS_WE) else $error("overflow wrote");
   fix16_time_a: assert property (take && op == 8'he8 |=> (BUSY && !DONE)[*8] ##1 BUSY ##1 DONE)
      else $error("to-16 timing");
   flt16_time_a: assert property (take && op == 8'he9 |-> ##16 DONE && WR.en && WR.words == 2'h2)
      else $error("from-16 timing");
   fix32_time_a: assert property (take && op == 8'hea |-> ##21 DONE && (WR.en || FIX_OVF_PI))
      else $error("to-32 timing");
   flt32_time_a: assert property (take && op == 8'heb |-> ##25 DONE && WR.en && WR.words == 2'h3)
      else $error("from-32 timing");
   cmp_reg_a: assert property (take && op inside {8'hf9, 8'hfb} |-> ##52 DONE && CS_WE && !WR.en && !FIX_OVF_PI)
      else $error("register compare");
   efc_mem_a: assert property (take && op == 8'hfa |-> ##65 DONE && CS_WE) else $error("extended compare timing");
endmodule // fcc_checker

bind fcc_top fcc_checker u_fcc_checker (.CORE_CLK, .RSTN, .START, .REQ, .BUSY, .DONE, .CS, .CS_WE, .WR, .FIX_OVF_PI);

/* test/fcc_seq_model.sv */
// Sequencer stand-in that presents requests to the datapath
`timescale 1ns/100ps
module fcc_seq_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench side
   input wire logic go,
   input wire fcc_pkg::fcc_req_t next_req,
   // Datapath side
   input wire logic busy,
   input wire logic done,
   output logic start,
   output fcc_pkg::fcc_req_t req
);
   // Start stays up until taken; operands held until done
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start <= 1'b0;
         req <= '0;
      end else if (go) begin
         start <= 1'b1;
         req <= next_req;
      end else if (start && !busy) begin
         start <= 1'b0;
      end else if (done) begin
         // Scrambled so stale operands cannot pass for held ones
         req <= ~req;
      end
   end
endmodule // fcc_seq_model

/* test/fcc_top_bench.sv */
// Self-checking bench for the float compare/convert datapath
`timescale 1ns/100ps
module fcc_top_bench;
   localparam logic [47:0] ONE = {24'h400000, 8'h01, 16'h0000};
   localparam logic [47:0] TWO = {24'h400000, 8'h02, 16'h0000};
   localparam logic [47:0] MONE = {24'hc00000, 8'h01, 16'h0000};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic go = 1'b0;
   fcc_pkg::fcc_req_t nreq = '0;
   logic start, busy, done, bad_op, cs_we, ovf;
   fcc_pkg::fcc_req_t req;
   logic [3:0] first_reg, base_reg, cs;
   logic [1:0] opnd_bus;
   fcc_pkg::fcc_wr_t wr;
   int n_fail = 0;
   int checks_done = 0;
   // 125 MHz core clock
   always #4 clk = ~clk;
   fcc_seq_model u_fcc_seq_model (.clk(clk), .rst_n(rst_n), .go(go), .next_req(nreq), .busy(busy), .done(done),
      .start(start), .req(req));
   fcc_top u_fcc_top (.CORE_CLK(clk), .RSTN(rst_n), .START(start), .REQ(req), .BUSY(busy), .DONE(done),
      .BAD_OP(bad_op), .FIRST_REGISTER(first_reg), .BASE_REGISTER(base_reg), .OPND_BUS(opnd_bus), .CS(cs),
      .CS_WE(cs_we), .WR(wr), .FIX_OVF_PI(ovf));
   // Verdict and end of run
   task automatic test_done();
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Single comparison point
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   // One request; checks edges from take to done, leaves bench in the done cycle
   task automatic run(input logic [15:0] ins, input logic [47:0] a, input logic [47:0] b, input int n);
      int k;
      nreq = '{instr: ins, first_val: a, dop: b};
      go = 1'b1;
      @(posedge clk);
      #1 go = 1'b0;
      @(posedge clk);
      // Taking edge is edge zero; DONE is sampled high at edge n
      k = 1;
      do begin
         @(posedge clk);
         #1 k++;
      end while (done !== 1'b1 && k < 100);
      chk(48'(k), 48'(n), "latency");
      if (k >= 100) begin
         test_done();
      end
   endtask
   // Compare: status code, operand cycles, nothing else touched
   task automatic cmp(input logic [15:0] ins, input logic [47:0] a, b, input logic [3:0] c, input int n,
      input logic [1:0] ob);
      run(ins, a, b, n);
      chk(48'(cs), 48'(c), "compare status");
      chk({cs_we, wr.en, ovf}, 3'b100, "compare strobes");
      chk(48'(opnd_bus), 48'(ob), "operand cycles");
   endtask
   // Conversion with a written result
   task automatic conv(input logic [15:0] ins, input logic [47:0] b, input int n, input logic [1:0] w,
      input logic [47:0] d, input logic [3:0] c);
      run(ins, 48'h0, b, n);
      chk({wr.en, ovf, wr.words, wr.idx}, {2'b10, w, ins[7:4]}, "write strobe");
      chk(wr.data & (~48'h0 << (16 * (3 - w))), d, "converted data");
      chk(48'(cs), 48'(c), "convert status");
   endtask
   // Exponent too large: overflow flag only, status kept
   task automatic ovf_case(input logic [15:0] ins, input logic [47:0] b, input int n);
      logic [3:0] c0;
      c0 = cs;
      run(ins, 48'h0, b, n);
      chk({ovf, wr.en, cs_we, cs}, {3'b100, c0}, "overflow");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      cmp(16'hf912, ONE | 48'h1, ONE, 4'h2, 52, 2'h0);
      cmp(16'hf834, ONE, TWO, 4'h1, 58, 2'h2);
      cmp(16'hfb56, ONE | 48'h1, ONE, 4'h4, 52, 2'h0);
      cmp(16'hfa78, MONE, ONE, 4'h1, 65, 2'h3);
      cmp(16'h3f00, ONE, MONE, 4'h4, 58, 2'h2);
      chk({base_reg, first_reg}, 8'hf0, "base form registers");
      cmp(16'h40d5, TWO, ONE, 4'h4, 58, 2'h2);
      chk({base_reg, first_reg}, 8'hc0, "indexed base registers");
      conv(16'he823, {24'h400000, 8'h0f, 16'h0}, 10, 2'h1, {16'h4000, 32'h0}, 4'h4);
      conv(16'he845, {24'ha00000, 8'h01, 16'h0}, 10, 2'h1, {16'hffff, 32'h0}, 4'h1);
      ovf_case(16'he867, {24'h400000, 8'h10, 16'h0}, 10);
      conv(16'he999, {16'h0001, 32'h0}, 16, 2'h2, ONE, 4'h4);
      conv(16'he9ab, {16'hffff, 32'h0}, 16, 2'h2, {24'h800000, 24'h0}, 4'h1);
      conv(16'he9cd, 48'h0, 16, 2'h2, 48'h0, 4'h2);
      conv(16'hea12, {24'h400000, 8'h1f, 16'h0}, 21, 2'h2, {32'h40000000, 16'h0}, 4'h4);
      ovf_case(16'hea34, {24'h400000, 8'h20, 16'h0}, 21);
      conv(16'heb56, {32'h00000001, 16'h0}, 25, 2'h3, ONE, 4'h4);
      conv(16'heb78, 48'h0, 25, 2'h3, 48'h0, 4'h2);
      run(16'h0000, 48'h0, 48'h0, 2);
      chk({bad_op, cs_we, wr.en}, 3'b100, "unhandled opcode");
      test_done();
   end
endmodule // fcc_top_bench
